/* include/ippm_pkg.sv */
/*
  Shared constants and types of the interrupt priority and power mode block.
  Assumes a 40 MHz core clock and a bus word of 32 bits with 8-bit registers.
*/
package ippm_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NUM_SRC = 15;
  // Register indices, byte addresses four times these (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_PRIO_LOW = 8'hB8;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hF8;
  localparam logic [7:0] IDX_ENABLE_FIRST = 8'hA8;
  localparam logic [7:0] IDX_ENABLE_SECOND = 8'hE8;
  localparam logic [7:0] IDX_CAN_COMMAND = 8'hC0;
  localparam logic [7:0] IDX_STATUS = 8'hC4;
  localparam logic [9:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_PRIO_LOW = {IDX_PRIO_LOW, 2'b00};
  localparam logic [9:0] ADDR_PRIO_HIGH = {IDX_PRIO_HIGH, 2'b00};
  localparam logic [9:0] ADDR_ENABLE_FIRST = {IDX_ENABLE_FIRST, 2'b00};
  localparam logic [9:0] ADDR_ENABLE_SECOND = {IDX_ENABLE_SECOND, 2'b00};
  localparam logic [9:0] ADDR_CAN_COMMAND = {IDX_CAN_COMMAND, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // Power control fields
  localparam int unsigned PC_BAUD_DOUBLE = 7;
  localparam int unsigned PC_WDOG_PERMIT = 4;
  localparam int unsigned PC_FLAG_B = 3;
  localparam int unsigned PC_FLAG_A = 2;
  localparam int unsigned PC_POWER_DOWN = 1;
  localparam int unsigned PC_HALT = 0;
  localparam logic [7:0] PC_WRITE_MASK = 8'h9F;
  localparam int unsigned EN_GLOBAL = 7;
  localparam int unsigned EN_CAN = 5;
  localparam int unsigned CAN_SLEEP_BIT = 4;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] PRIO_LOW_MASK = 8'h7F;
  // Vectors
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int unsigned VEC_STEP_SHIFT = 3;
  // Machine cycle is 12 oscillator periods of the core clock
  localparam int unsigned MC_CLOCKS = 12;
  localparam int unsigned WAKE_PULSE_MC = 6144;
  localparam int unsigned CAN_RESET_MC = 8192;
  localparam int unsigned EXT_RESET_OSC = 24;
  // Fixed service order by vector index, best first
  typedef logic [3:0] ippm_idx_t;
  typedef ippm_idx_t ippm_order_t [NUM_SRC];
  localparam ippm_order_t SERVICE_ORDER = '{4'h0, 4'h5, 4'hA, 4'h1, 4'h6, 4'hB, 4'h2, 4'h7,
                                            4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE};
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_DOWN, PM_WAKE} ippm_mode_e;
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ippm_bus_req_s;
  typedef struct packed {
    logic addr_latch_high;
    logic code_fetch_strobe;
    logic pwm_high;
    logic port0_float;
    logic port2_address;
    logic can_tx_recessive;
  } ippm_pins_s;
endpackage : ippm_pkg

/* src/ippm_top.sv */
/*
  Interrupt priority resolution, vectoring and power mode sequencing.
  Assumes sources are synchronous levels from on-chip logic, the core pulses
  vector_taken and service_return, and pins can_rx and powerdown permit are async.
*/
// Summary of operation
// - Low-group priority register, seven source bits
// - High-group priority register, timer 2 sources
// - Vectors 0003H upward, eight apart, fixed order
// - High priority request wins over low
// - Equal priority resolved by fixed service order
// - Low routine preempted only by high
// - Power control register layout and reset
// - Watchdog load permit cleared after counter load
// - Power-down set only with permit input high
// - Power-down wins over halt when both written
// - CAN sleep bit, wakes on dominant receive
// - Idle halts core, stops timer2, PWM high
// - Enabled active interrupt clears halt request
// - External or watchdog reset ends idle
// - Power-down stops oscillator, forces CAN sleep
// - Power-down exits on reset or enabled wake
// - Wake pulse 6144 machine cycles, CAN kept
// - Pulse beyond 8192 cycles resets CAN too
// - Reset reinitialises registers, RAM untouched
// - Strobe and port levels in idle, power-down
// - CAN transmit pins recessive in sleep, down
// - Request needs own enable and global gate
`timescale 1ns/1ps
module ippm_top (
  input wire logic clk,
  input wire logic rst,
  input wire ippm_pkg::ippm_bus_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [ippm_pkg::NUM_SRC-1:0] irq_sources,
  input wire logic vector_taken,
  input wire logic service_return,
  input wire logic watchdog_counter_loaded,
  input wire logic watchdog_overflow,
  input wire logic powerdown_permit_input,
  input wire logic can_rx_in_a,
  input wire logic can_rx_in_b,
  input wire logic rst_pin_held,
  input wire logic external_program,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic core_halt,
  output logic osc_stop,
  output logic timer2_clear,
  output logic adc_abort,
  output logic can_clock_gate,
  output logic system_reset_out,
  output logic can_reset_out,
  output logic baud_double,
  output ippm_pkg::ippm_pins_s pin_state
);
  import ippm_pkg::*;

  localparam int unsigned WAKE_CLKS = WAKE_PULSE_MC * MC_CLOCKS;
  localparam int unsigned CAN_RST_CLKS = CAN_RESET_MC * MC_CLOCKS;
  localparam int unsigned EXT_RST_CLKS = EXT_RESET_OSC;
  localparam logic [16:0] WAKE_LAST = 17'(WAKE_CLKS - 1);
  localparam logic [16:0] CAN_LAST = 17'(CAN_RST_CLKS - 1);
  localparam logic [4:0] EXT_LAST = 5'(EXT_RST_CLKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] permit_sync_q, permit_sync_d;
  logic [1:0] rxa_sync_q, rxa_sync_d;
  logic [1:0] rxb_sync_q, rxb_sync_d;
  logic [1:0] rstp_sync_q, rstp_sync_d;
  logic permit_s, dominant_s, rstpin_s;

  always_comb begin
    permit_sync_d = {permit_sync_q[0], powerdown_permit_input};
    rxa_sync_d = {rxa_sync_q[0], can_rx_in_a};
    rxb_sync_d = {rxb_sync_q[0], can_rx_in_b};
    rstp_sync_d = {rstp_sync_q[0], rst_pin_held};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      permit_sync_q <= 2'h0;
      rxa_sync_q <= 2'h3;
      rxb_sync_q <= 2'h3;
      rstp_sync_q <= 2'h0;
    end else begin
      permit_sync_q <= permit_sync_d;
      rxa_sync_q <= rxa_sync_d;
      rxb_sync_q <= rxb_sync_d;
      rstp_sync_q <= rstp_sync_d;
    end
  end

  assign permit_s = permit_sync_q[1];
  assign dominant_s = ~rxa_sync_q[1] | ~rxb_sync_q[1];
  assign rstpin_s = rstp_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register file and mode machine
  logic [7:0] power_control_q, power_control_d;
  logic [7:0] prio_lo_q, prio_lo_d;
  logic [7:0] prio_hi_q, prio_hi_d;
  logic [7:0] en0_q, en0_d;
  logic [7:0] en1_q, en1_d;
  logic can_sleep_q, can_sleep_d;
  logic [1:0] in_service_q, in_service_d;
  ippm_mode_e mode_q, mode_d;
  logic [16:0] cnt_q, cnt_d;
  logic [4:0] ext_cnt_q, ext_cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic rd_done_q, rd_done_d;
  logic can_hold_q, can_hold_d;
  logic [NUM_SRC-1:0] src_en, src_hi;
  logic winner_found, winner_hi;
  ippm_idx_t winner;
  logic wr_pc, wr_can, any_active;
  logic internal_reset;

  // Enables and priority bits laid out in vector order
  assign src_en = {en1_q[7:4], en0_q[6], en1_q[3:0], en0_q[5:0]};
  assign src_hi = {prio_hi_q[7:4], prio_lo_q[6], prio_hi_q[3:0], prio_lo_q[5:0]};

  always_comb begin
    logic [NUM_SRC-1:0] live;
    logic found_hi, found_lo;
    ippm_idx_t best_hi, best_lo;
    live = irq_sources & src_en & {NUM_SRC{en0_q[EN_GLOBAL]}};
    found_hi = 1'b0;
    found_lo = 1'b0;
    best_hi = 4'h0;
    best_lo = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (live[SERVICE_ORDER[i]] && src_hi[SERVICE_ORDER[i]]) begin
        found_hi = 1'b1;
        best_hi = SERVICE_ORDER[i];
      end
      if (live[SERVICE_ORDER[i]] && !src_hi[SERVICE_ORDER[i]]) begin
        found_lo = 1'b1;
        best_lo = SERVICE_ORDER[i];
      end
    end
    any_active = |live;
    // High level never nests; low nests only under high
    winner_hi = found_hi && !in_service_q[1];
    winner_found = winner_hi || (found_lo && in_service_q == 2'b00);
    winner = winner_hi ? best_hi : best_lo;
  end

  assign wr_pc = avs_req.write && avs_req.address == ADDR_POWER_CONTROL;
  assign wr_can = avs_req.write && avs_req.address == ADDR_CAN_COMMAND;
  assign internal_reset = rst || (mode_q == PM_WAKE) || watchdog_overflow || (ext_cnt_q == EXT_LAST);

  always_comb begin
    power_control_d = power_control_q;
    prio_lo_d = prio_lo_q;
    prio_hi_d = prio_hi_q;
    en0_d = en0_q;
    en1_d = en1_q;
    can_sleep_d = can_sleep_q;
    in_service_d = in_service_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    can_hold_d = 1'b0;
    ext_cnt_d = rstpin_s ? ((ext_cnt_q == EXT_LAST) ? ext_cnt_q : ext_cnt_q + 5'h01) : 5'h00;
    if (avs_req.write) begin
      unique case (avs_req.address)
        ADDR_POWER_CONTROL: begin
          power_control_d = (avs_req.writedata[7:0] & PC_WRITE_MASK) | (power_control_q & ~PC_WRITE_MASK);
          if (!permit_s) begin
            power_control_d[PC_POWER_DOWN] = power_control_q[PC_POWER_DOWN];
          end
        end
        ADDR_PRIO_LOW: prio_lo_d = avs_req.writedata[7:0] & PRIO_LOW_MASK;
        ADDR_PRIO_HIGH: prio_hi_d = avs_req.writedata[7:0];
        ADDR_ENABLE_FIRST: en0_d = avs_req.writedata[7:0];
        ADDR_ENABLE_SECOND: en1_d = avs_req.writedata[7:0];
        ADDR_CAN_COMMAND: can_sleep_d = avs_req.writedata[CAN_SLEEP_BIT];
        default: begin
        end
      endcase
    end
    if (watchdog_counter_loaded) begin
      power_control_d[PC_WDOG_PERMIT] = 1'b0;
    end
    if (can_sleep_q && dominant_s && !wr_can) begin
      can_sleep_d = 1'b0;
    end
    if (power_control_d[PC_POWER_DOWN]) begin
      can_sleep_d = 1'b1;
    end
    // Taking a vector raises its level; return drops the highest active level
    if (service_return) begin
      in_service_d = in_service_q[1] ? {1'b0, in_service_q[0]} : 2'b00;
    end
    if (vector_taken && winner_found) begin
      in_service_d = winner_hi ? {1'b1, in_service_d[0]} : {in_service_d[1], 1'b1};
    end
    unique case (mode_q)
      PM_RUN: begin
        if (power_control_q[PC_POWER_DOWN]) begin
          mode_d = PM_DOWN;
        end else if (power_control_q[PC_HALT]) begin
          mode_d = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (any_active && !wr_pc) begin
          power_control_d[PC_HALT] = 1'b0;
          mode_d = PM_RUN;
        end
      end
      PM_DOWN: begin
        if (dominant_s && en0_q[EN_GLOBAL] && en0_q[EN_CAN]) begin
          mode_d = PM_WAKE;
          cnt_d = 17'h00000;
        end
      end
      PM_WAKE: begin
        // A held pin stretches the pulse; the CAN side is spared until the long limit
        can_hold_d = 1'b1;
        if (cnt_q != CAN_LAST) begin
          cnt_d = cnt_q + 17'h00001;
        end
        if (cnt_q >= WAKE_LAST && !rstpin_s) begin
          mode_d = PM_RUN;
        end
      end
    endcase
    // A completed reset resumes normal running; the wake pulse keeps its own exit
    if (mode_q != PM_WAKE && (watchdog_overflow || ext_cnt_q == EXT_LAST)) begin
      mode_d = PM_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= PM_RUN;
      cnt_q <= 17'h00000;
      ext_cnt_q <= 5'h00;
      can_hold_q <= 1'b0;
      can_sleep_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      ext_cnt_q <= ext_cnt_d;
      can_hold_q <= can_hold_d;
      can_sleep_q <= (mode_q == PM_WAKE && cnt_q == CAN_LAST) ? 1'b0 : can_sleep_d;
    end
  end

  // Core-side registers follow every internal reset; the CAN bit does not
  always_ff @(posedge clk) begin
    if (internal_reset) begin
      power_control_q <= RST_POWER_CONTROL;
      prio_lo_q <= RST_PRIO;
      prio_hi_q <= RST_PRIO;
      en0_q <= RST_ENABLE;
      en1_q <= RST_ENABLE;
      in_service_q <= 2'b00;
    end else begin
      power_control_q <= power_control_d;
      prio_lo_q <= prio_lo_d;
      prio_hi_q <= prio_hi_d;
      en0_q <= en0_d;
      en1_q <= en1_d;
      in_service_q <= in_service_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon read path: writes take one cycle, reads answer one cycle later
  always_comb begin
    rdata_d = 32'h00000000;
    rd_done_d = avs_req.read && !rd_done_q;
    unique case (avs_req.address)
      ADDR_POWER_CONTROL: rdata_d[7:0] = power_control_q;
      ADDR_PRIO_LOW: rdata_d[7:0] = prio_lo_q;
      ADDR_PRIO_HIGH: rdata_d[7:0] = prio_hi_q;
      ADDR_ENABLE_FIRST: rdata_d[7:0] = en0_q;
      ADDR_ENABLE_SECOND: rdata_d[7:0] = en1_q;
      ADDR_CAN_COMMAND: rdata_d[CAN_SLEEP_BIT] = can_sleep_q;
      ADDR_STATUS: rdata_d[7:0] = {2'b00, in_service_q, 2'b00, mode_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
      rd_done_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_done_q <= rd_done_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = avs_req.read && !rd_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic [15:0] vec_q, vec_d;
  logic req_q, req_d;
  always_comb begin
    vec_d = VEC_BASE + {9'h000, winner, 3'b000};
    req_d = winner_found && (mode_q == PM_RUN || mode_q == PM_IDLE);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= VEC_BASE;
      req_q <= 1'b0;
    end else begin
      vec_q <= vec_d;
      req_q <= req_d;
    end
  end
  assign irq_vector = vec_q;
  assign irq_request = req_q;
  assign core_halt = mode_q != PM_RUN;
  assign osc_stop = mode_q == PM_DOWN;
  assign timer2_clear = mode_q == PM_IDLE || mode_q == PM_DOWN;
  assign adc_abort = mode_q == PM_IDLE || mode_q == PM_DOWN;
  assign can_clock_gate = can_sleep_q;
  assign system_reset_out = mode_q == PM_WAKE;
  assign can_reset_out = mode_q == PM_WAKE && cnt_q == CAN_LAST && can_hold_q;
  assign baud_double = power_control_q[PC_BAUD_DOUBLE];
  always_comb begin
    pin_state.addr_latch_high = mode_q != PM_DOWN;
    pin_state.code_fetch_strobe = mode_q != PM_DOWN;
    pin_state.pwm_high = mode_q != PM_RUN;
    pin_state.port0_float = external_program && mode_q != PM_RUN;
    pin_state.port2_address = external_program && mode_q == PM_IDLE;
    pin_state.can_tx_recessive = can_sleep_q || mode_q == PM_DOWN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_permit;
    @(posedge clk) disable iff (rst) (wr_pc && !permit_s && !power_control_q[PC_POWER_DOWN] && mode_q == PM_RUN)
      |=> !power_control_q[PC_POWER_DOWN];
  endproperty
  a_permit: assert property (p_permit) else $error("power-down set without permit");
  property p_pd_wins;
    @(posedge clk) disable iff (rst) (mode_q == PM_RUN && power_control_q[PC_POWER_DOWN] && !internal_reset)
      |=> mode_q == PM_DOWN;
  endproperty
  a_pd_wins: assert property (p_pd_wins) else $error("power-down did not win");
  property p_sleep_forced;
    @(posedge clk) disable iff (rst) power_control_q[PC_POWER_DOWN] |-> can_sleep_q;
  endproperty
  a_sleep_forced: assert property (p_sleep_forced) else $error("CAN not asleep in power-down");
  property p_wdog;
    @(posedge clk) disable iff (rst) (watchdog_counter_loaded && mode_q == PM_RUN) |=> !power_control_q[PC_WDOG_PERMIT];
  endproperty
  a_wdog: assert property (p_wdog) else $error("load permit not cleared");
  property p_gate;
    @(posedge clk) disable iff (rst) !en0_q[EN_GLOBAL] |=> !irq_request;
  endproperty
  a_gate: assert property (p_gate) else $error("request with global gate low");
  property p_no_nest_high;
    @(posedge clk) disable iff (rst) in_service_q[1] |=> !irq_request;
  endproperty
  a_no_nest_high: assert property (p_no_nest_high) else $error("high routine preempted");
  sequence s_wake_start;
    mode_q == PM_DOWN ##1 mode_q == PM_WAKE;
  endsequence
  property p_wake_pulse;
    @(posedge clk) disable iff (rst) s_wake_start |-> system_reset_out [*8];
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too short");
  property p_wake_len;
    @(posedge clk) disable iff (rst) (system_reset_out && cnt_q < WAKE_LAST) |=> system_reset_out;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake pulse ended early");
  property p_recessive;
    @(posedge clk) disable iff (rst) can_sleep_q |-> pin_state.can_tx_recessive;
  endproperty
  a_recessive: assert property (p_recessive) else $error("CAN tx not recessive");
  property p_vector;
    @(posedge clk) disable iff (rst) irq_request |-> (irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073);
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
endmodule : ippm_top

/* sim/ippm_core_model.sv */
/*
  Behavioural model of the processor core facing the interrupt block.
  Assumes the bench arms it once for each vector it should accept, and asks for returns.
*/
`timescale 1ns/1ps
module ippm_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic arm,
  input wire logic ret,
  output logic vector_taken,
  output logic service_return,
  output logic [15:0] taken_vector
);
  logic armed_q;
  ////////////////////////////////////////////////////////////////////////
  // One acceptance per arming, so a held source is not taken over and over
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_q <= 1'b0;
      vector_taken <= 1'b0;
      service_return <= 1'b0;
      taken_vector <= 16'h0000;
    end else begin
      service_return <= ret;
      vector_taken <= 1'b0;
      if (arm) begin
        armed_q <= 1'b1;
      end else if (armed_q && irq_request === 1'b1 && !vector_taken) begin
        vector_taken <= 1'b1;
        taken_vector <= irq_vector;
        armed_q <= 1'b0;
      end
    end
  end
endmodule : ippm_core_model

/* sim/ippm_tb_top.sv */
/*
  Self-checking bench of the interrupt priority and power mode block.
  Assumes a 40 MHz clock, Avalon-MM register access and the core model beside it.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ippm_tb_top;
  import ippm_pkg::*;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ippm_bus_req_s avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NUM_SRC-1:0] irq_sources = '0;
  logic vector_taken, service_return, arm = 1'b0, ret = 1'b0;
  logic wd_loaded = 1'b0, wd_over = 1'b0, permit = 1'b0, rx_a = 1'b1, rx_b = 1'b1, ext_prog = 1'b0, rst_pin = 1'b0;
  logic irq_request, core_halt, osc_stop, timer2_clear, adc_abort, can_clock_gate;
  logic system_reset_out, can_reset_out, baud_double;
  logic [15:0] irq_vector, taken_vector;
  ippm_pins_s pin_state;
  logic [7:0] q;
  logic [NUM_SRC-1:0] m;
  int mismatches = 0, checks_done = 0, cyc = 0, n;
  logic can_rst_seen;
  int order [15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
  ////////////////////////////////////////////////////////////////////////
  ippm_top i_ippm_top (.clk(clk), .rst(rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_sources(irq_sources), .vector_taken(vector_taken),
    .service_return(service_return), .watchdog_counter_loaded(wd_loaded), .watchdog_overflow(wd_over),
    .powerdown_permit_input(permit), .can_rx_in_a(rx_a), .can_rx_in_b(rx_b), .rst_pin_held(rst_pin),
    .external_program(ext_prog), .irq_request(irq_request), .irq_vector(irq_vector), .core_halt(core_halt),
    .osc_stop(osc_stop), .timer2_clear(timer2_clear), .adc_abort(adc_abort), .can_clock_gate(can_clock_gate),
    .system_reset_out(system_reset_out), .can_reset_out(can_reset_out), .baud_double(baud_double),
    .pin_state(pin_state));
  ippm_core_model i_ippm_core_model (.clk(clk), .rst(rst), .irq_request(irq_request), .irq_vector(irq_vector),
    .arm(arm), .ret(ret), .vector_taken(vector_taken), .service_return(service_return),
    .taken_vector(taken_vector));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : wait_cyc
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [9:0] a, input logic wr, input logic [7:0] d, output logic [7:0] r);
    int t;
    t = 0;
    avs_req <= '{address: a, read: !wr, write: wr, writedata: {24'h000000, d}};
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (t >= 50) mismatches++;
    r = avs_readdata[7:0];
    avs_req <= '0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic take(input logic [15:0] exp);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    n = 0;
    while (vector_taken !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    wait_cyc(4);
    `CHK(taken_vector, exp)
  endtask : take
  ////////////////////////////////////////////////////////////////////////
  initial begin
    wait_cyc(16);
    rst <= 1'b0;
    @(posedge clk);
    bus(ADDR_POWER_CONTROL, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    bus(ADDR_PRIO_LOW, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    bus(ADDR_PRIO_HIGH, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    bus(10'h004, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    wr(ADDR_PRIO_LOW, 8'hFF); bus(ADDR_PRIO_LOW, 1'b0, 8'h00, q); `CHK(q, 8'h7F)
    wr(ADDR_PRIO_HIGH, 8'hFF); bus(ADDR_PRIO_HIGH, 1'b0, 8'h00, q); `CHK(q, 8'hFF)
    wr(ADDR_POWER_CONTROL, 8'hFE); bus(ADDR_POWER_CONTROL, 1'b0, 8'h00, q); `CHK(q, 8'h9C)
    `CHK(baud_double, 1'b1)
    wr(ADDR_POWER_CONTROL, 8'h10);
    wd_loaded <= 1'b1; @(posedge clk); wd_loaded <= 1'b0; wait_cyc(2);
    bus(ADDR_POWER_CONTROL, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    // Every source alone and in service order at low level, then high level, global gate and nesting
    wr(ADDR_PRIO_LOW, 8'h00); wr(ADDR_PRIO_HIGH, 8'h00);
    wr(ADDR_ENABLE_FIRST, 8'hFF); wr(ADDR_ENABLE_SECOND, 8'hFF);
    for (int i = 0; i < 15; i++) begin
      irq_sources <= 15'h0001 << i; wait_cyc(3);
      `CHK(irq_vector, 16'h0003 + 16'(8 * i))
    end
    for (int k = 0; k < 15; k++) begin
      m = '0;
      for (int j = k; j < 15; j++) m[order[j]] = 1'b1;
      irq_sources <= m; wait_cyc(3);
      `CHK(irq_vector, 16'h0003 + 16'(8 * order[k]))
    end
    irq_sources <= 15'h7FFF; wr(ADDR_PRIO_HIGH, 8'h80); wait_cyc(2);
    `CHK(irq_vector, 16'h0073)
    wr(ADDR_ENABLE_FIRST, 8'h7F); wait_cyc(2); `CHK(irq_request, 1'b0)
    wr(ADDR_ENABLE_FIRST, 8'hFF);
    irq_sources <= 15'h0002; wait_cyc(3); take(16'h000B);
    irq_sources <= 15'h0003; wait_cyc(4); `CHK(irq_request, 1'b0)
    irq_sources <= 15'h4003; wait_cyc(4); `CHK(irq_request, 1'b1)
    `CHK(irq_vector, 16'h0073)
    take(16'h0073); `CHK(irq_request, 1'b0)
    ret <= 1'b1; @(posedge clk); ret <= 1'b0; wait_cyc(4);
    `CHK(irq_request, 1'b1)
    // Sleep and wake of the CAN controller by bus activity
    irq_sources <= '0;
    wr(ADDR_CAN_COMMAND, 8'h10); wait_cyc(2); `CHK(can_clock_gate, 1'b1)
    bus(ADDR_CAN_COMMAND, 1'b0, 8'h00, q); `CHK(q[4], 1'b1)
    `CHK(pin_state.can_tx_recessive, 1'b1)
    rx_b <= 1'b0; wait_cyc(6); rx_b <= 1'b1;
    bus(ADDR_CAN_COMMAND, 1'b0, 8'h00, q); `CHK(q[4], 1'b0)
    rst <= 1'b1; wait_cyc(3); rst <= 1'b0; @(posedge clk);
    bus(ADDR_PRIO_HIGH, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    // Idle entry, then exit by an enabled source and by a watchdog reset
    wr(ADDR_ENABLE_FIRST, 8'h81); ext_prog <= 1'b1;
    wr(ADDR_POWER_CONTROL, 8'h01); wait_cyc(3);
    `CHK({core_halt, timer2_clear, adc_abort, pin_state.pwm_high}, 4'hF)
    `CHK({pin_state.addr_latch_high, pin_state.code_fetch_strobe, pin_state.port2_address}, 3'h7)
    `CHK(pin_state.port0_float, 1'b1)
    bus(ADDR_STATUS, 1'b0, 8'h00, q); `CHK(q, 8'h01)
    irq_sources <= 15'h0001; wait_cyc(4); `CHK(core_halt, 1'b0)
    bus(ADDR_POWER_CONTROL, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    irq_sources <= '0; ext_prog <= 1'b0;
    wr(ADDR_POWER_CONTROL, 8'h01); wait_cyc(3); `CHK(core_halt, 1'b1)
    wd_over <= 1'b1; @(posedge clk); wd_over <= 1'b0; wait_cyc(4);
    `CHK(core_halt, 1'b0)
    // Idle again, ended by the reset pin held for two machine cycles
    wr(ADDR_POWER_CONTROL, 8'h01); wait_cyc(3); rst_pin <= 1'b1; wait_cyc(20);
    `CHK(core_halt, 1'b1)
    wait_cyc(10); `CHK(core_halt, 1'b0)
    `CHK(system_reset_out, 1'b0)
    rst_pin <= 1'b0;
    // Power-down with idle written too, left by a CAN wake-up
    permit <= 1'b1; wait_cyc(4);
    wr(ADDR_ENABLE_FIRST, 8'hA0); wr(ADDR_CAN_COMMAND, 8'h10);
    wr(ADDR_POWER_CONTROL, 8'h03); wait_cyc(3);
    `CHK(osc_stop, 1'b1)
    `CHK({can_clock_gate, pin_state.can_tx_recessive, pin_state.pwm_high}, 3'h7)
    `CHK({pin_state.addr_latch_high, pin_state.code_fetch_strobe}, 2'h0)
    rx_a <= 1'b0; n = 0;
    while (system_reset_out !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    rx_a <= 1'b1; n = 0; can_rst_seen = 1'b0;
    while (system_reset_out === 1'b1 && n < 80000) begin
      if (can_reset_out === 1'b1) can_rst_seen = 1'b1;
      @(posedge clk);
      n++;
    end
    `CHK(n, WAKE_PULSE_MC * MC_CLOCKS)
    `CHK(can_rst_seen, 1'b0)
    wait_cyc(4);
    bus(ADDR_POWER_CONTROL, 1'b0, 8'h00, q); `CHK(q, 8'h00)
    `CHK(osc_stop, 1'b0)
    end_of_test();
  end
endmodule : ippm_tb_top
